/* hdl/rsl_lamp_encoder.sv */
/*
 * Status lamp encoder: turns reader and network conditions into colour
 * and blink patterns on three two-colour front lamps, with a Wishbone
 * slave for control, status and interrupts.
 * Assumes all condition inputs come from logic on mclk.
 */
// The register addresses and the Wishbone register port were chosen for this implementation.
// Behaviour
// - Drive three independent lamps: reader status, network status, Ethernet port.
// - During initialization or self test, reader lamp blinks green, reading impossible.
// - After successful self test with monitoring active, reader lamp steady green.
// - Each good decode darkens reader lamp briefly, then steady green again.
// - Each failed read: dark briefly, red briefly, then green.
// - Service mode shows steady orange; reading possible, no host result data.
// - Warning blinks red, reading continues; device error steady red, no reading.
// - Network lamp dark without communication or with protocols not released.
// - Network lamp blinks green while initializing and establishing communication.
// - Network lamp steady green once connected and talking to the host.
// - Communication, connection or address errors blink red; network error steady red.
module rsl_lamp_encoder #(
    parameter int BLINK_HALF_CYC = rsl_pkg::BLINK_HALF_CYC_DEF,
    parameter int PULSE_CYC = rsl_pkg::PULSE_CYC_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic self_test_busy,
    input wire logic monitor_active,
    input wire logic good_read,
    input wire logic no_read,
    input wire logic service_mode,
    input wire logic warning,
    input wire logic device_error,
    input wire logic comm_possible,
    input wire logic proto_released,
    input wire logic net_connecting,
    input wire logic net_connected,
    input wire logic comm_error,
    input wire logic addr_failed,
    input wire logic net_error,
    input wire logic eth_link_up,
    input wire logic eth_activity,
    output logic reader_status_lamp_grn,
    output logic reader_status_lamp_red,
    output logic network_status_lamp_grn,
    output logic network_status_lamp_red,
    output logic eth_lamp_grn,
    output logic eth_lamp_yel,
    output logic reading_possible,
    output logic host_data_en,
    output logic irq
);
    import rsl_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [31:0] blink_cnt;
        logic blink_ph;
        logic [31:0] pulse_cnt;
        rsl_pulse_t pulse;
        rsl_rdr_mode_t rdr_mode;
        rsl_net_mode_t net_mode;
        logic lamp_en;
        logic [IRQ_W-1:0] int_stat;
        logic [IRQ_W-1:0] int_mask;
        logic dev_err_d;
        logic net_err_d;
        logic ack;
        logic [31:0] dat;
        logic [5:0] lamps;
        logic read_ok;
        logic host_en;
    } rsl_state_t;

    rsl_state_t st_reg;
    rsl_state_t st_next;

    logic req;
    logic wr;
    logic [IRQ_W-1:0] ev;
    logic [31:0] status_word;

    function automatic logic [31:0] rd_mux(input logic [3:0] adr,
                                           input rsl_state_t s,
                                           input logic [31:0] stw);
        logic [31:0] v;
        v = 32'h0;
        unique case (adr)
            ADR_CTRL: v[CTRL_LAMP_EN] = s.lamp_en;
            ADR_STATUS: v = stw;
            ADR_INT_STAT: v[IRQ_W-1:0] = s.int_stat;
            ADR_INT_MASK: v[IRQ_W-1:0] = s.int_mask;
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign wr = req && wb_we_i && wb_sel_i[0];

    // Status word and event vector placed by named field positions
    always_comb begin
        status_word = 32'h0;
        status_word[ST_RDR_LSB +: $bits(rsl_rdr_mode_t)] = st_reg.rdr_mode;
        status_word[ST_NET_LSB +: $bits(rsl_net_mode_t)] = st_reg.net_mode;
        status_word[ST_READ_OK] = st_reg.read_ok;
        status_word[ST_HOST_EN] = st_reg.host_en;
        ev = '0;
        ev[IRQ_GOOD] = good_read;
        ev[IRQ_NOREAD] = no_read;
        ev[IRQ_DEV_ERR] = device_error && !st_reg.dev_err_d;
        ev[IRQ_NET_ERR] = net_error && !st_reg.net_err_d;
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic rg;
        logic rr;
        logic ng;
        logic nr;
        rg = 1'b0;
        rr = 1'b0;
        ng = 1'b0;
        nr = 1'b0;
        st_next = st_reg;
        st_next.dev_err_d = device_error;
        st_next.net_err_d = net_error;

        // Shared blink time base
        if (st_reg.blink_cnt == 32'(BLINK_HALF_CYC - 1)) begin
            st_next.blink_cnt = 32'h0;
            st_next.blink_ph = !st_reg.blink_ph;
        end else begin
            st_next.blink_cnt = st_reg.blink_cnt + 32'h1;
        end

        // Brief pulse sequencer; a new event restarts it
        if (good_read) begin
            st_next.pulse = PULSE_GOOD_OFF;
            st_next.pulse_cnt = 32'(PULSE_CYC - 1);
        end else if (no_read) begin
            st_next.pulse = PULSE_NR_OFF;
            st_next.pulse_cnt = 32'(PULSE_CYC - 1);
        end else if (st_reg.pulse != PULSE_IDLE) begin
            if (st_reg.pulse_cnt != 32'h0) begin
                st_next.pulse_cnt = st_reg.pulse_cnt - 32'h1;
            end else if (st_reg.pulse == PULSE_NR_OFF) begin
                st_next.pulse = PULSE_NR_RED;
                st_next.pulse_cnt = 32'(PULSE_CYC - 1);
            end else begin
                st_next.pulse = PULSE_IDLE;
            end
        end

        // Reader lamp, highest priority first
        if (self_test_busy || !monitor_active) begin
            st_next.rdr_mode = RDR_INIT;
            rg = st_next.blink_ph;
        end else if (device_error) begin
            st_next.rdr_mode = RDR_ERROR;
            rr = 1'b1;
        end else if (warning) begin
            st_next.rdr_mode = RDR_WARN;
            rr = st_next.blink_ph;
        end else if (service_mode) begin
            st_next.rdr_mode = RDR_SERVICE;
            rg = 1'b1;
            rr = 1'b1;
        end else begin
            unique case (st_next.pulse)
                PULSE_GOOD_OFF: st_next.rdr_mode = RDR_GOOD_OFF;
                PULSE_NR_OFF: st_next.rdr_mode = RDR_NR_OFF;
                PULSE_NR_RED: begin
                    st_next.rdr_mode = RDR_NR_RED;
                    rr = 1'b1;
                end
                PULSE_IDLE: begin
                    st_next.rdr_mode = RDR_READY;
                    rg = 1'b1;
                end
            endcase
        end
        st_next.read_ok = !(self_test_busy || !monitor_active
                            || device_error);
        st_next.host_en = st_next.read_ok && !service_mode;

        // Network lamp
        if (!comm_possible || !proto_released) begin
            st_next.net_mode = NET_DARK;
        end else if (net_error) begin
            st_next.net_mode = NET_ERR;
            nr = 1'b1;
        end else if (comm_error || addr_failed) begin
            st_next.net_mode = NET_COMM_ERR;
            nr = st_next.blink_ph;
        // Still negotiating counts as establishing, so keep blinking
        end else if (net_connected && !net_connecting) begin
            st_next.net_mode = NET_OK;
            ng = 1'b1;
        end else begin
            st_next.net_mode = NET_INIT;
            ng = st_next.blink_ph;
        end

        // Lamps blank together when software disables them
        st_next.lamps = {rg, rr, ng, nr,
                         eth_link_up && !eth_activity,
                         eth_activity && st_next.blink_ph};
        if (!st_reg.lamp_en) begin
            st_next.lamps = 6'h0;
        end

        // Bus slave: one wait state, unmapped reads give zero
        st_next.ack = req;
        st_next.dat = rd_mux(wb_adr_i, st_reg, status_word);
        if (wr && wb_adr_i == ADR_CTRL) begin
            st_next.lamp_en = wb_dat_i[CTRL_LAMP_EN];
        end
        if (wr && wb_adr_i == ADR_INT_MASK) begin
            st_next.int_mask = wb_dat_i[IRQ_W-1:0];
        end
        // Set wins over a write-one-to-clear in the same cycle
        if (wr && wb_adr_i == ADR_INT_STAT) begin
            st_next.int_stat = st_reg.int_stat & ~wb_dat_i[IRQ_W-1:0];
        end
        st_next.int_stat = st_next.int_stat | ev;

        if (!rst_n) begin
            st_next = '0;
            st_next.lamp_en = CTRL_LAMP_EN_RST;
            st_next.int_mask = IRQ_MASK_RST;
            st_next.pulse = PULSE_IDLE;
            st_next.rdr_mode = RDR_INIT;
            st_next.net_mode = NET_DARK;
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.dat;
    assign {reader_status_lamp_grn, reader_status_lamp_red,
            network_status_lamp_grn, network_status_lamp_red,
            eth_lamp_grn, eth_lamp_yel} = st_reg.lamps;
    assign reading_possible = st_reg.read_ok;
    assign host_data_en = st_reg.host_en;
    assign irq = |(st_reg.int_stat & st_reg.int_mask);

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic quiet;
    assign quiet = st_reg.lamp_en && monitor_active && !self_test_busy
                   && !device_error && !warning && !service_mode;

    ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_answers_req_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    init_blink_a: assert property (
        self_test_busy && st_reg.lamp_en |=> !reader_status_lamp_red
        && !reading_possible)
        else $error("init shows red or allows reading");
    ready_green_a: assert property (
        quiet && !good_read && !no_read && st_reg.pulse == PULSE_IDLE
        |=> reader_status_lamp_grn && !reader_status_lamp_red)
        else $error("ready state not steady green");
    good_read_dark_a: assert property (
        quiet && good_read |=> !reader_status_lamp_grn
        && !reader_status_lamp_red)
        else $error("good read did not darken lamp");
    noread_red_a: assert property (
        quiet && $rose(reader_status_lamp_red)
        |-> $past(st_reg.pulse) == PULSE_NR_OFF)
        else $error("failed-read red not preceded by dark");
    service_orange_a: assert property (
        service_mode && quiet == 1'b0 && st_reg.lamp_en && monitor_active
        && !self_test_busy && !device_error && !warning
        |=> reader_status_lamp_grn && reader_status_lamp_red
        && !host_data_en && reading_possible)
        else $error("service mode not orange");
    error_red_a: assert property (
        device_error && !self_test_busy && monitor_active && st_reg.lamp_en
        |=> reader_status_lamp_red && !reader_status_lamp_grn
        && !reading_possible)
        else $error("device error not steady red");
    net_dark_a: assert property (
        !proto_released |=> !network_status_lamp_grn
        && !network_status_lamp_red)
        else $error("network lamp lit without protocols");
    net_green_a: assert property (
        st_reg.lamp_en && comm_possible && proto_released && net_connected
        && !net_connecting && !net_error && !comm_error && !addr_failed
        |=> network_status_lamp_grn && !network_status_lamp_red)
        else $error("connected network not green");
    net_err_red_a: assert property (
        st_reg.lamp_en && comm_possible && proto_released && net_error
        |=> network_status_lamp_red && !network_status_lamp_grn)
        else $error("network error not steady red");
    irq_event_a: assert property (
        good_read && st_reg.int_mask[IRQ_GOOD] |=> irq)
        else $error("unmasked event did not raise irq");

    good_read_c: cover property (quiet && good_read ##1
                                 !reader_status_lamp_grn);
    no_read_c: cover property (st_reg.pulse == PULSE_NR_RED);
    w1c_c: cover property (wr && wb_adr_i == ADR_INT_STAT && |ev);

endmodule

/* hdl/rsl_pkg.sv */
/*
 * Constants for the reader status lamp encoder: register map, field
 * positions, interrupt bits and lamp timing.
 * Assumes a single 10 MHz system clock and a 32-bit Wishbone bus.
 */
package rsl_pkg;

    // ==========================================================
    // Clock and lamp timing
    // ==========================================================
    localparam int CLK_HZ = 10_000_000;
    localparam int BLINK_HALF_MS = 250;
    localparam int PULSE_MS = 100;
    localparam int BLINK_HALF_CYC_DEF = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int PULSE_CYC_DEF = (CLK_HZ / 1000) * PULSE_MS;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_STATUS = 4'h4;
    localparam logic [3:0] ADR_INT_STAT = 4'h8;
    localparam logic [3:0] ADR_INT_MASK = 4'hC;

    localparam int CTRL_LAMP_EN = 0;
    localparam logic CTRL_LAMP_EN_RST = 1'b1;

    localparam int ST_RDR_LSB = 0;
    localparam int ST_NET_LSB = 4;
    localparam int ST_READ_OK = 8;
    localparam int ST_HOST_EN = 9;

    localparam int IRQ_W = 4;
    localparam int IRQ_GOOD = 0;
    localparam int IRQ_NOREAD = 1;
    localparam int IRQ_DEV_ERR = 2;
    localparam int IRQ_NET_ERR = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    // ==========================================================
    // Modes shown in the status register, and pulse sequencer states
    // ==========================================================
    typedef enum logic [3:0] {
        RDR_INIT, RDR_READY, RDR_GOOD_OFF, RDR_NR_OFF, RDR_NR_RED,
        RDR_SERVICE, RDR_WARN, RDR_ERROR
    } rsl_rdr_mode_t;

    typedef enum logic [3:0] {
        NET_DARK, NET_INIT, NET_OK, NET_COMM_ERR, NET_ERR
    } rsl_net_mode_t;

    typedef enum logic [1:0] {
        PULSE_IDLE, PULSE_GOOD_OFF, PULSE_NR_OFF, PULSE_NR_RED
    } rsl_pulse_t;

endpackage

/* tb/rsl_lamp_model.sv */
/*
 * Front lamp model: decodes the six lamp drives into one colour code
 * per lamp (0 dark, 1 green, 2 red, 3 orange, 4 yellow).
 * Assumes a high drive means a lit lamp.
 */
module rsl_lamp_model (
    input wire logic [5:0] drv,
    output logic [2:0] rdr_col,
    output logic [2:0] net_col,
    output logic [2:0] eth_col
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Colour decoding
    // ==========================================================
    // Both dies lit read as orange
    assign rdr_col = {1'b0, drv[1], drv[0]};
    assign net_col = {1'b0, drv[3], drv[2]};
    // Yellow wins while traffic blinks
    assign eth_col = drv[5] ? 3'h4 : {2'h0, drv[4]};
endmodule

/* tb/test_rsl_lamp_encoder.sv */
/*
 * Self-checking bench for the lamp encoder: Wishbone register access,
 * interrupts and every lamp pattern.
 * Assumes short blink and pulse counts set through the parameters.
 */
module test_rsl_lamp_encoder;
    timeunit 1ns;
    timeprecision 1ns;
    import rsl_pkg::*;
    localparam int BH = 8;
    localparam int PC = 5;
    // Network table: {blink, colour, net_error..comm_possible}
    localparam logic [10:0] NT [7] = '{11'h001, 11'h487, 11'h08B,
                                       11'h51B, 11'h52B, 11'h143,
                                       11'h48F};
    logic mclk, rst_n, cyc, stb, we, ack, irq, rdp, hde;
    logic [3:0] adr;
    logic [31:0] wdat, rdat;
    logic [15:0] c, rnd;
    logic [5:0] drv;
    logic [2:0] rc, nc, ec;
    logic [31:0] q[$];
    int fails, checked, cyc_n;

    rsl_lamp_encoder #(.BLINK_HALF_CYC(BH), .PULSE_CYC(PC))
            rsl_lamp_encoder_i (
        .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .self_test_busy(c[0]),
        .monitor_active(c[1]), .good_read(c[2]), .no_read(c[3]),
        .service_mode(c[4]), .warning(c[5]), .device_error(c[6]),
        .comm_possible(c[7]), .proto_released(c[8]),
        .net_connecting(c[9]), .net_connected(c[10]),
        .comm_error(c[11]), .addr_failed(c[12]), .net_error(c[13]),
        .eth_link_up(c[14]), .eth_activity(c[15]),
        .reader_status_lamp_grn(drv[0]), .reader_status_lamp_red(drv[1]),
        .network_status_lamp_grn(drv[2]),
        .network_status_lamp_red(drv[3]), .eth_lamp_grn(drv[4]),
        .eth_lamp_yel(drv[5]), .reading_possible(rdp),
        .host_data_en(hde), .irq(irq));

    rsl_lamp_model rsl_lamp_model_i (.drv(drv), .rdr_col(rc),
        .net_col(nc), .eth_col(ec));

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic close_out();
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // Read data is noted here and checked by the monitor at ack
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        if (!w)
            q.push_back(d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= w ? d : 32'h0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20)
            fails++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic set(input int i, input logic v);
        @(posedge mclk);
        c[i] <= v;
    endtask

    task automatic pulse(input int i);
        set(i, 1'b1);
        set(i, 1'b0);
    endtask

    task automatic at(input int k, input logic [2:0] e);
        repeat (k) @(negedge mclk);
        cmp("reader colour", 32'(e), 32'(rc));
    endtask

    // Steady: colour held throughout; blink: colour alternates with dark
    task automatic lamp(input int w, input logic [2:0] e, input logic bl);
        int on, off;
        logic [2:0] v;
        on = 0;
        off = 0;
        repeat (2) @(posedge mclk);
        repeat (4 * BH) begin
            @(negedge mclk);
            v = w == 0 ? rc : (w == 1 ? nc : ec);
            on += int'(v === e);
            off += int'(v === 3'h0);
        end
        checked++;
        if (bl ? (on == 0 || off == 0 || on + off != 4 * BH)
               : on != 4 * BH) begin
            fails++;
            $display("mismatch lamp%0d expected %0d seen %0d", w, e, v);
        end
    endtask

    // ==========================================================
    // Clock, monitor and timeout
    // ==========================================================
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (ack === 1'b1 && !we && q.size() > 0)
            cmp("read data", q.pop_front(), rdat);
    end

    always @(posedge mclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 4000) begin
            fails++;
            close_out();
        end
    end

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        wdat = 32'h0;
        fails = 0;
        checked = 0;
        cyc_n = 0;
        c = 16'h0001;
        rnd = 16'hD298;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        cmp("lamps in reset", 32'h0, 32'(drv));
        @(posedge mclk);
        rst_n <= 1'b1;
        lamp(0, 3'h1, 1'b1);
        cmp("reading_possible", 32'h0, 32'(rdp));
        bus(1'b0, ADR_CTRL, 32'h1);
        bus(1'b0, ADR_INT_MASK, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        lamp(1, 3'h0, 1'b0);
        @(posedge mclk);
        c <= 16'h0002;
        lamp(0, 3'h1, 1'b0);
        bus(1'b0, ADR_STATUS, 32'h301);
        pulse(2);
        at(3, 3'h0);
        cmp("irq masked", 32'h0, 32'(irq));
        at(5, 3'h1);
        bus(1'b0, ADR_INT_STAT, 32'h1);
        bus(1'b1, ADR_INT_MASK, 32'h1);
        @(negedge mclk);
        cmp("irq", 32'h1, 32'(irq));
        bus(1'b1, ADR_INT_STAT, 32'h1);
        @(negedge mclk);
        cmp("irq", 32'h0, 32'(irq));
        pulse(3);
        at(3, 3'h0);
        at(5, 3'h2);
        at(5, 3'h1);
        set(4, 1'b1);
        lamp(0, 3'h3, 1'b0);
        cmp("host_data_en", 32'h0, 32'(hde));
        cmp("reading_possible", 32'h1, 32'(rdp));
        set(5, 1'b1);
        lamp(0, 3'h2, 1'b1);
        cmp("reading_possible", 32'h1, 32'(rdp));
        set(6, 1'b1);
        lamp(0, 3'h2, 1'b0);
        cmp("reading_possible", 32'h0, 32'(rdp));
        @(posedge mclk);
        c[6:4] <= 3'h0;
        for (int i = 0; i < 7; i++) begin
            @(posedge mclk);
            c[13:7] <= NT[i][6:0];
            lamp(1, NT[i][9:7], NT[i][10]);
        end
        bus(1'b0, ADR_INT_STAT, 32'hE);
        rnd = lfsr(rnd);
        bus(1'b1, ADR_INT_MASK, {28'h0, rnd[3:0]});
        bus(1'b0, ADR_INT_MASK, {28'h0, rnd[3:0]});
        @(negedge mclk);
        cmp("irq", 32'(|(rnd[3:0] & 4'hE)), 32'(irq));
        set(14, 1'b1);
        lamp(2, 3'h1, 1'b0);
        set(15, 1'b1);
        lamp(2, 3'h4, 1'b1);
        bus(1'b1, ADR_CTRL, 32'h0);
        lamp(0, 3'h0, 1'b0);
        cmp("lamps blanked", 32'h0, 32'(drv));
        bus(1'b1, ADR_CTRL, 32'h1);
        lamp(0, 3'h1, 1'b0);
        close_out();
    end
endmodule
